/* File: mpp_pkg.sv */
// Shared constants, role encoding and helpers for the multipurpose pin block
// Contract
// - Up to four microphones, two per data pin
// - Any pin becomes mic data by role
// - Mic bitstreams always pass through decimation filters
// - Channels 0-3: pair A left/right, pair B
// - Seven selectable roles per pin
// - Hardware inputs offer glitch-suppressing debounce
// - Pin state in input and output roles updates once per sample period
// - Program inputs valid only for input roles
// - Program outputs reach pin only in output roles
// - Output pin carries one program Boolean
package mpp_pkg;

  // ==========================================================================
  // Sizes
  localparam int MPP_PINS = 26;
  localparam int MPP_MIC_CH = 4;
  localparam int MPP_PIN_IDX_W = 5;
  localparam int MPP_MIC_W = 20;
  localparam int MPP_DECIM_RATIO = 64;
  localparam int MPP_DEB_CYCLES = 8;
  localparam int MPP_CLK_HZ = 40_000_000;

  // ==========================================================================
  // Register offsets
  localparam logic [15:0] MPP_MIC_CTRL_A_ADDR = 16'hF560;
  localparam logic [15:0] MPP_MIC_CTRL_B_ADDR = 16'hF561;
  localparam logic [15:0] MPP_ROLE_BASE = 16'hF400;
  localparam logic [15:0] MPP_SWIN_BASE = 16'hF440;
  localparam logic [15:0] MPP_READ_BASE = 16'hF480;

  // ==========================================================================
  // Field positions and reset values
  localparam int MPP_ROLE_LSB = 0;
  localparam int MPP_ROLE_W = 3;
  localparam int MPP_DEB_BIT = 3;
  localparam int MPP_MIC_EN_BIT = 0;
  localparam int MPP_MIC_PIN_LSB = 1;
  localparam logic [3:0] MPP_ROLE_RST = 4'h0;
  localparam logic [15:0] MPP_MIC_CTRL_RST = 16'h0000;

  // ==========================================================================
  // Pin roles
  typedef enum logic [2:0] {
    MPP_ROLE_HW_IN = 3'h0,
    MPP_ROLE_SW_IN = 3'h1,
    MPP_ROLE_OUT_PU = 3'h2,
    MPP_ROLE_OUT_NOPU = 3'h3,
    MPP_ROLE_PDM = 3'h4,
    MPP_ROLE_PANIC = 3'h5,
    MPP_ROLE_SPI_SS = 3'h6
  } mpp_role_t;

  // Input roles feed the program
  function automatic logic mpp_is_input(input logic [2:0] role);
    return (role == MPP_ROLE_HW_IN) || (role == MPP_ROLE_SW_IN);
  endfunction

  // Output roles take the program value
  function automatic logic mpp_is_output(input logic [2:0] role);
    return (role == MPP_ROLE_OUT_PU) || (role == MPP_ROLE_OUT_NOPU);
  endfunction

endpackage

/* File: mpp_cic_decim.sv */
// Third-order CIC decimator turning a one-bit PDM stream into PCM words
`timescale 1ns/1ps
module mpp_cic_decim
  import mpp_pkg::*;
#(
  parameter int DECIM = MPP_DECIM_RATIO,
  parameter int OUT_W = MPP_MIC_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic bit_valid,
  input wire logic bit_in,
  output logic [OUT_W-1:0] sample_data,
  output logic sample_valid
);
  localparam int CNT_W = $clog2(DECIM);

  logic [OUT_W-1:0] integ1_reg, integ2_reg, integ3_reg;
  logic [OUT_W-1:0] dly1_reg, dly2_reg, dly3_reg;
  logic [OUT_W-1:0] comb1, comb2, comb3, step;
  logic [CNT_W-1:0] phase_reg;

  // Map bit to +1 or -1 and form comb differences
  always_comb begin
    step = bit_in ? OUT_W'(1) : {OUT_W{1'b1}};
    comb1 = integ3_reg - dly1_reg;
    comb2 = comb1 - dly2_reg;
    comb3 = comb2 - dly3_reg;
  end

  // Integrators at bit rate, combs at output rate
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      integ1_reg <= '0;
      integ2_reg <= '0;
      integ3_reg <= '0;
      dly1_reg <= '0;
      dly2_reg <= '0;
      dly3_reg <= '0;
      phase_reg <= '0;
      sample_data <= '0;
      sample_valid <= 1'b0;
    end else if (!enable) begin
      integ1_reg <= '0;
      integ2_reg <= '0;
      integ3_reg <= '0;
      dly1_reg <= '0;
      dly2_reg <= '0;
      dly3_reg <= '0;
      phase_reg <= '0;
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= 1'b0;
      if (bit_valid) begin
        integ1_reg <= integ1_reg + step;
        integ2_reg <= integ2_reg + integ1_reg;
        integ3_reg <= integ3_reg + integ2_reg;
        if (phase_reg == CNT_W'(DECIM - 1)) begin
          phase_reg <= '0;
          dly1_reg <= integ3_reg;
          dly2_reg <= comb1;
          dly3_reg <= comb2;
          sample_data <= comb3;
          sample_valid <= 1'b1;
        end else begin
          phase_reg <= phase_reg + CNT_W'(1);
        end
      end
    end
  end
endmodule // mpp_cic_decim

/* File: mpp_pins.sv */
// Multipurpose pin role selection, sampling and PDM microphone front end
`timescale 1ns/1ps
module mpp_pins
  import mpp_pkg::*;
#(
  parameter int PINS = MPP_PINS,
  parameter int DEB_CYCLES = MPP_DEB_CYCLES,
  parameter int DECIM = MPP_DECIM_RATIO,
  parameter int MIC_W = MPP_MIC_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_wr_data,
  output logic [15:0] reg_rd_data,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  output logic [PINS-1:0] pin_pullup_en,
  input wire logic sample_strobe,
  input wire logic [PINS-1:0] gp_out_value,
  output logic [PINS-1:0] gp_in_value,
  output logic [PINS-1:0] gp_in_valid,
  input wire logic panic_flag,
  input wire logic spi_ss_n,
  input wire logic bit_clock,
  output logic [MPP_MIC_CH*MIC_W-1:0] mic_sample_data,
  output logic [MPP_MIC_CH-1:0] mic_sample_valid
);
  localparam int DEB_W = $clog2(DEB_CYCLES) + 1;

  // ==========================================================================
  // Register storage
  logic [3:0] role_reg [PINS];
  logic [PINS-1:0] swin_reg;
  logic [15:0] mic_ctrl_a_reg, mic_ctrl_b_reg;

  // Synchronisers and debounce state
  logic [PINS-1:0] pin_meta_reg, pin_sync_reg, deb_val_reg;
  logic [DEB_W-1:0] deb_cnt_reg [PINS];
  logic bclk_meta_reg, bclk_sync_reg, bclk_prev_reg;

  // Per-sample latches
  logic [PINS-1:0] out_latch_reg;

  // Microphone lanes
  logic [MPP_MIC_CH-1:0] mic_en, mic_bit, mic_bit_valid;
  logic bclk_rise, bclk_fall;

  // Index of an address within a pin bank, with a hit flag
  function automatic logic bank_hit(input logic [15:0] addr, input logic [15:0] base,
                                    output logic [MPP_PIN_IDX_W-1:0] idx);
    logic [15:0] diff;
    diff = addr - base;
    idx = diff[MPP_PIN_IDX_W-1:0];
    return (addr >= base) && (diff < 16'(PINS));
  endfunction

  // ==========================================================================
  // Input synchronisers for pins and the bit clock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      bclk_meta_reg <= 1'b0;
      bclk_sync_reg <= 1'b0;
      bclk_prev_reg <= 1'b0;
    end else begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
      bclk_meta_reg <= bit_clock;
      bclk_sync_reg <= bclk_meta_reg;
      bclk_prev_reg <= bclk_sync_reg;
    end
  end

  // ==========================================================================
  // Register writes from the slave control port
  always_ff @(posedge clk_sys or negedge reset_n) begin
    logic [MPP_PIN_IDX_W-1:0] widx;
    if (!reset_n) begin
      for (int i = 0; i < PINS; i++) begin
        role_reg[i] <= MPP_ROLE_RST;
      end
      swin_reg <= '0;
      mic_ctrl_a_reg <= MPP_MIC_CTRL_RST;
      mic_ctrl_b_reg <= MPP_MIC_CTRL_RST;
    end else if (reg_wr_en) begin
      if (reg_addr == MPP_MIC_CTRL_A_ADDR) begin
        mic_ctrl_a_reg <= reg_wr_data;
      end else if (reg_addr == MPP_MIC_CTRL_B_ADDR) begin
        mic_ctrl_b_reg <= reg_wr_data;
      end else if (bank_hit(reg_addr, MPP_ROLE_BASE, widx)) begin
        role_reg[widx] <= reg_wr_data[3:0];
      end else if (bank_hit(reg_addr, MPP_SWIN_BASE, widx)) begin
        swin_reg[widx] <= reg_wr_data[0];
      end
    end
  end

  // Registered read data, unmapped addresses read zero
  always_ff @(posedge clk_sys or negedge reset_n) begin
    logic [MPP_PIN_IDX_W-1:0] ridx;
    if (!reset_n) begin
      reg_rd_data <= '0;
    end else if (reg_rd_en) begin
      if (reg_addr == MPP_MIC_CTRL_A_ADDR) begin
        reg_rd_data <= mic_ctrl_a_reg;
      end else if (reg_addr == MPP_MIC_CTRL_B_ADDR) begin
        reg_rd_data <= mic_ctrl_b_reg;
      end else if (bank_hit(reg_addr, MPP_ROLE_BASE, ridx)) begin
        reg_rd_data <= {12'h000, role_reg[ridx]};
      end else if (bank_hit(reg_addr, MPP_SWIN_BASE, ridx)) begin
        reg_rd_data <= {15'h0000, swin_reg[ridx]};
      end else if (bank_hit(reg_addr, MPP_READ_BASE, ridx)) begin
        reg_rd_data <= {15'h0000, gp_in_value[ridx]};
      end else begin
        reg_rd_data <= 16'h0000;
      end
    end
  end

  // ==========================================================================
  // Debounce: a new level must hold DEB_CYCLES clocks before it is taken
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      deb_val_reg <= '0;
      for (int i = 0; i < PINS; i++) begin
        deb_cnt_reg[i] <= '0;
      end
    end else begin
      for (int i = 0; i < PINS; i++) begin
        if (pin_sync_reg[i] == deb_val_reg[i]) begin
          deb_cnt_reg[i] <= '0;
        end else if (deb_cnt_reg[i] == DEB_W'(DEB_CYCLES - 1)) begin
          deb_val_reg[i] <= pin_sync_reg[i];
          deb_cnt_reg[i] <= '0;
        end else begin
          deb_cnt_reg[i] <= deb_cnt_reg[i] + DEB_W'(1);
        end
      end
    end
  end

  // ==========================================================================
  // Once-per-sample update of program inputs and output latches
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gp_in_value <= '0;
      gp_in_valid <= '0;
      out_latch_reg <= '0;
    end else if (sample_strobe) begin
      for (int i = 0; i < PINS; i++) begin
        gp_in_valid[i] <= mpp_is_input(role_reg[i][2:0]);
        case (role_reg[i][2:0])
          MPP_ROLE_HW_IN: begin
            gp_in_value[i] <= role_reg[i][MPP_DEB_BIT] ? deb_val_reg[i] : pin_sync_reg[i];
          end
          MPP_ROLE_SW_IN: begin
            gp_in_value[i] <= swin_reg[i];
          end
          default: begin
            gp_in_value[i] <= 1'b0;
          end
        endcase
        if (mpp_is_output(role_reg[i][2:0])) begin
          out_latch_reg[i] <= gp_out_value[i];
        end
      end
    end
  end

  // ==========================================================================
  // Pin drivers by role
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= '0;
      pin_oe <= '0;
      pin_pullup_en <= '0;
    end else begin
      for (int i = 0; i < PINS; i++) begin
        case (role_reg[i][2:0])
          MPP_ROLE_OUT_PU: begin
            pin_out[i] <= out_latch_reg[i];
            pin_oe[i] <= 1'b1;
            pin_pullup_en[i] <= 1'b1;
          end
          MPP_ROLE_OUT_NOPU: begin
            pin_out[i] <= out_latch_reg[i];
            pin_oe[i] <= 1'b1;
            pin_pullup_en[i] <= 1'b0;
          end
          MPP_ROLE_PANIC: begin
            pin_out[i] <= panic_flag;
            pin_oe[i] <= 1'b1;
            pin_pullup_en[i] <= 1'b0;
          end
          MPP_ROLE_SPI_SS: begin
            pin_out[i] <= spi_ss_n;
            pin_oe[i] <= 1'b1;
            pin_pullup_en[i] <= 1'b0;
          end
          default: begin
            pin_out[i] <= 1'b0;
            pin_oe[i] <= 1'b0;
            pin_pullup_en[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Microphone lanes: left on bit clock rise, right on fall
  assign bclk_rise = bclk_sync_reg & ~bclk_prev_reg;
  assign bclk_fall = ~bclk_sync_reg & bclk_prev_reg;

  always_comb begin
    logic [15:0] ctrl;
    logic [MPP_PIN_IDX_W-1:0] pidx;
    logic pair_en;
    ctrl = 16'h0000;
    pidx = '0;
    pair_en = 1'b0;
    mic_en = '0;
    mic_bit = '0;
    mic_bit_valid = '0;
    for (int p = 0; p < MPP_MIC_CH / 2; p++) begin
      ctrl = (p == 0) ? mic_ctrl_a_reg : mic_ctrl_b_reg;
      pidx = ctrl[MPP_MIC_PIN_LSB +: MPP_PIN_IDX_W];
      pair_en = ctrl[MPP_MIC_EN_BIT] && (32'(pidx) < PINS)
                && (role_reg[pidx][2:0] == MPP_ROLE_PDM);
      mic_en[2*p] = pair_en;
      mic_en[2*p+1] = pair_en;
      mic_bit[2*p] = pin_sync_reg[pidx];
      mic_bit[2*p+1] = pin_sync_reg[pidx];
      mic_bit_valid[2*p] = pair_en & bclk_rise;
      mic_bit_valid[2*p+1] = pair_en & bclk_fall;
    end
  end

  // One decimator per channel, always in the path
  for (genvar c = 0; c < MPP_MIC_CH; c++) begin : g_mic
    mpp_cic_decim #(
      .DECIM(DECIM),
      .OUT_W(MIC_W)
    ) u_decim (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .enable(mic_en[c]),
      .bit_valid(mic_bit_valid[c]),
      .bit_in(mic_bit[c]),
      .sample_data(mic_sample_data[c*MIC_W +: MIC_W]),
      .sample_valid(mic_sample_valid[c])
    );
  end
endmodule // mpp_pins

/* File: mpp_pins_assertions.sv */
// Port-level property checker for the multipurpose pin block
`timescale 1ns/1ps
module mpp_pins_assertions
  import mpp_pkg::*;
#(
  parameter int PINS = MPP_PINS,
  parameter int MIC_W = MPP_MIC_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_rd_data,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe,
  input wire logic [PINS-1:0] pin_pullup_en,
  input wire logic sample_strobe,
  input wire logic [PINS-1:0] gp_in_value,
  input wire logic [PINS-1:0] gp_in_valid,
  input wire logic [MPP_MIC_CH-1:0] mic_sample_valid
);
  // ====
  // Timing and masking properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // A word on channel 0 is followed by at least eight quiet clock cycles
  sequence s_quiet8;
    !mic_sample_valid[0] [*8];
  endsequence
  property p_mic_gap;
    mic_sample_valid[0] |=> s_quiet8;
  endproperty
  a_mic_gap: assert property (p_mic_gap) else $error("ch0 words too close");
  property p_lr_apart;
    mic_sample_valid[0] |-> !mic_sample_valid[1];
  endproperty
  a_lr_apart: assert property (p_lr_apart) else $error("left and right together");
  property p_rd_hold;
    !$past(reg_rd_en) |-> $stable(reg_rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_unmapped;
    reg_rd_en && reg_addr[15:12] != 4'hF |=> reg_rd_data == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_valid_hold;
    !$past(sample_strobe) |-> $stable(gp_in_valid);
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("valid moved off strobe");
  property p_value_hold;
    !$past(sample_strobe) |-> $stable(gp_in_value);
  endproperty
  a_value_hold: assert property (p_value_hold) else $error("input moved off strobe");
  property p_in_masked;
    (gp_in_value & ~gp_in_valid) == '0;
  endproperty
  a_in_masked: assert property (p_in_masked) else $error("input shown on non-input");
  property p_pu_oe;
    (pin_pullup_en & ~pin_oe) == '0;
  endproperty
  a_pu_oe: assert property (p_pu_oe) else $error("pull-up without drive");
  property p_out_strobe;
    ((pin_out ^ $past(pin_out)) & pin_pullup_en & $past(pin_pullup_en)) != '0
      |-> $past(sample_strobe, 2);
  endproperty
  a_out_strobe: assert property (p_out_strobe) else $error("output moved off strobe");
endmodule // mpp_pins_assertions

bind mpp_pins mpp_pins_assertions #(.PINS(PINS), .MIC_W(MIC_W)) i_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en),
  .reg_rd_data(reg_rd_data), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pullup_en(pin_pullup_en), .sample_strobe(sample_strobe),
  .gp_in_value(gp_in_value), .gp_in_valid(gp_in_valid),
  .mic_sample_valid(mic_sample_valid));

/* File: mpp_mic_model.sv */
// Behavioural pair of PDM microphones sharing one data line
`timescale 1ns/1ps
module mpp_mic_model #(
  parameter bit LEFT_LVL = 1'h1,
  parameter bit RIGHT_LVL = 1'h0
) (
  input wire logic bit_clock,
  output logic mic_data
);
  initial mic_data = 1'h0;
  // Right mic answers after a rise, left after a fall; junk in between
  always @(posedge bit_clock) begin
    #30 mic_data = ~mic_data;
    #30 mic_data = RIGHT_LVL;
  end
  always @(negedge bit_clock) begin
    #30 mic_data = ~mic_data;
    #30 mic_data = LEFT_LVL;
  end
endmodule // mpp_mic_model

/* File: tb_top.sv */
// Self-checking bench for the multipurpose pin block
`timescale 1ns/1ps
module tb_top;
  import mpp_pkg::*;
  logic clk_sys = 1'h0, reset_n = 1'h0, reg_wr_en = 1'h0, reg_rd_en = 1'h0;
  logic sample_strobe = 1'h0, panic_flag = 1'h0, spi_ss_n = 1'h1;
  logic bit_clock = 1'h0, bclk_run = 1'h0, mic_a, mic_b;
  logic [15:0] reg_addr = '0, reg_wr_data = '0, reg_rd_data, d, v;
  logic [23:0] pin_drv = '0;
  logic [25:0] gp_out_value = '0, pin_out, pin_oe, pin_pullup_en;
  logic [25:0] gp_in_value, gp_in_valid, ev, sw;
  logic [79:0] mic_sample_data;
  logic [3:0] mic_sample_valid;
  logic [2:0] role [26];
  logic [15:0] ra [4] = '{16'hF560, 16'hF561, 16'hF400, 16'h0100};
  int bad_count = 0, n_compared = 0, cnt [4];
  wire [25:0] pin_in = {mic_b, mic_a, pin_drv};
  // ====
  // Clocks, design and microphones
  always #12.5 clk_sys = ~clk_sys;
  always #100 bit_clock = bclk_run ? ~bit_clock : 1'h0;
  always @(posedge clk_sys) for (int c = 0; c < 4; c++) if (mic_sample_valid[c]) cnt[c]++;
  mpp_pins #(.DEB_CYCLES(2), .DECIM(8)) i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
    .sample_strobe(sample_strobe), .gp_out_value(gp_out_value),
    .gp_in_value(gp_in_value), .gp_in_valid(gp_in_valid), .panic_flag(panic_flag),
    .spi_ss_n(spi_ss_n), .bit_clock(bit_clock), .mic_sample_data(mic_sample_data),
    .mic_sample_valid(mic_sample_valid));
  // Pair A uses the model's default levels: left high, right low
  mpp_mic_model i_mic_a (.bit_clock(bit_clock),
    .mic_data(mic_a));
  mpp_mic_model #(.LEFT_LVL(1'h0), .RIGHT_LVL(1'h1)) i_mic_b (.bit_clock(bit_clock),
    .mic_data(mic_b));
  // ====
  // Helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] x);
    tick(1);
    reg_addr = a;
    reg_wr_data = x;
    reg_wr_en = 1'h1;
    tick(1);
    reg_wr_en = 1'h0;
  endtask
  task automatic rd(input logic [15:0] a);
    tick(1);
    reg_addr = a;
    reg_rd_en = 1'h1;
    tick(1);
    reg_rd_en = 1'h0;
    d = reg_rd_data;
  endtask
  task automatic strobe;
    tick(8);
    sample_strobe = 1'h1;
    tick(1);
    sample_strobe = 1'h0;
    tick(3);
  endtask
  task automatic run_bits(input int n);
    cnt = '{0, 0, 0, 0};
    bclk_run = 1'h1;
    #(200 * n);
    bclk_run = 1'h0;
    tick(20);
  endtask
  // Value a driven pin should carry for its role
  function automatic logic exp_out(input logic [2:0] r, input int i);
    if (r == 3'h5) return panic_flag;
    if (r == 3'h6) return spi_ss_n;
    return gp_out_value[i];
  endfunction
  initial begin
    #1000000;
    bad_count++;
    complete_run();
  end
  // ====
  // Main sequence
  initial begin
    void'($urandom(32'h6793));
    tick(8);
    reset_n = 1'h1;
    foreach (ra[k]) begin
      rd(ra[k]);
      check(d, 16'h0000);
    end
    v = 16'($urandom) & 16'h003E;
    wr(MPP_MIC_CTRL_A_ADDR, v);
    rd(MPP_MIC_CTRL_A_ADDR);
    check(d, v);
    // Four successive role codes on each pin with random pin and program values
    for (int rep = 0; rep < 4; rep++) begin
      pin_drv = 24'($urandom);
      gp_out_value = 26'($urandom);
      panic_flag = 1'($urandom);
      spi_ss_n = 1'($urandom);
      sw = 26'($urandom);
      for (int i = 0; i < 26; i++) begin
        role[i] = 3'((i + rep) % 8);
        wr(MPP_ROLE_BASE + 16'(i), {13'h0000, role[i]});
        wr(MPP_SWIN_BASE + 16'(i), {15'h0000, sw[i]});
      end
      strobe();
      for (int i = 0; i < 26; i++) begin
        ev[i] = role[i] == 3'h0 ? pin_in[i] : role[i] == 3'h1 ? sw[i] : 1'h0;
        check(gp_in_valid[i], role[i] < 3'h2);
        check(gp_in_value[i], ev[i]);
        check(pin_oe[i], role[i] inside {3'h2, 3'h3, 3'h5, 3'h6});
        check(pin_pullup_en[i], role[i] == 3'h2);
        if (pin_oe[i] === 1'h1) check(pin_out[i], exp_out(role[i], i));
        rd(MPP_ROLE_BASE + 16'(i));
        check(d[3:0], {1'h0, role[i]});
        rd(MPP_READ_BASE + 16'(i));
        check(d[0], ev[i]);
      end
    end
    pin_drv = ~pin_drv;
    tick(8);
    check(gp_in_value, ev);
    // One-cycle glitch is dropped by debounce, a held level passes
    wr(MPP_ROLE_BASE, 16'h0008);
    pin_drv[0] = 1'h0;
    strobe();
    // Glitch reaches the second flip-flop exactly when the strobe is taken
    pin_drv[0] = 1'h1;
    tick(1);
    pin_drv[0] = 1'h0;
    tick(1);
    sample_strobe = 1'h1;
    tick(1);
    sample_strobe = 1'h0;
    tick(3);
    check(gp_in_value[0], 1'h0);
    pin_drv[0] = 1'h1;
    strobe();
    check(gp_in_value[0], 1'h1);
    // Two microphone pairs on pins 24 and 25
    wr(16'hF418, 16'h0004);
    wr(16'hF419, 16'h0004);
    wr(MPP_MIC_CTRL_A_ADDR, 16'h0031);
    wr(MPP_MIC_CTRL_B_ADDR, 16'h0033);
    run_bits(48);
    for (int c = 0; c < 4; c++) check(cnt[c] >= 5, 1'h1);
    check($signed(mic_sample_data[19:0]) > $signed(mic_sample_data[39:20]), 1'h1);
    check($signed(mic_sample_data[59:40]) < $signed(mic_sample_data[79:60]), 1'h1);
    wr(MPP_MIC_CTRL_B_ADDR, 16'h0032);
    run_bits(24);
    check(cnt[2], 0);
    check(cnt[0] >= 2, 1'h1);
    // Enabled pair whose data pin has left the PDM role stays silent
    wr(16'hF418, 16'h0000);
    run_bits(24);
    check(cnt[0], 0);
    check(cnt[1], 0);
    complete_run();
  end
endmodule // tb_top
